// >>> core/mbe_classifier.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Interface unit parity error reports bus parity.
// - Memory unit parity error reports bus/module-low.
// - Bus parity report outranks bus/module-low.
// - Lockstep or buffer faults report module error.
// - Interface unit arbitration mismatch reports bus arbitration.
// - Memory unit arbitration mismatch reports bus/module-high.
// - Bus arbitration outranks bus/module-high.
// - Error-line parity: line parity or bus/module-high.
// - Memory unit halts on stuck-low error line.
// - Memory-only parity error bars second bus.
// - Timeout length programmable, 16 us to 2 s.
// - Expired timeout acts as pseudo-reply, never an error report.
// - Waiting node signals bus error to processor.
// - Bus parity check enabled, software disable bit.
// - Arbitration lockstep enabled, software disable bit.
// - Error-line parity check always active.
// - Test Detection inverts both parity check bits on own read data.
// - Test Detection inverts comparators, forces line error.
// - Test Detection ignores software disables.
// - Report only highest priority: module, arbitration, parity.
// - Interlaced parity: odd even-lines, even odd-lines.
// - Error message: 16 bits plus even parity.
module mbe_classifier
	import mbe_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Memory bus.
	input  wire mbe_xfer_t   memory_bus_data_i,
	input  wire logic        own_read_data_i,
	input  wire mbe_arb_t    arb_master_i,
	input  wire mbe_arb_t    arb_checker_i,
	input  wire logic        module_fault_i,
	input  wire logic        new_request_line_i,
	input  wire logic        reply_i,
	// Error-report line.
	input  wire logic        erl_bit_valid_i,
	input  wire logic        error_report_line_i,
	input  wire logic        erl_stuck_low_i,
	// Outcomes.
	output mbe_rpt_t         report_o,
	output logic             report_valid_o,
	output logic             pseudo_reply_o,
	output logic             bus_error_o,
	output logic             halt_o,
	output logic             second_bus_bar_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Returns {odd-line bit, even-line bit}; the even lines carry odd parity.
	function automatic logic [1:0] mbe_par_gen(input logic [18:0] s);
		logic ev;
		logic od;
		ev = 1'b1;
		od = 1'b0;
		for (int i = 0; i < MBE_BUS_BITS; i++) begin
			if (i % 2 == 0) begin
				ev = ev ^ s[i];
			end else begin
				od = od ^ s[i];
			end
		end
		return {od, ev};
	endfunction

	// Report codes are ordered so that the larger code wins arbitration.
	function automatic mbe_rpt_t mbe_max(input mbe_rpt_t a, input mbe_rpt_t b);
		return (a > b) ? a : b;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0]  ctrl;
		logic [16:0] to_dur;
		logic [16:0] tick_cnt;
		logic [16:0] to_cnt;
		logic        waiting;
		logic        pseudo;
		logic        buserr;
		logic        halt;
		logic        bar;
		mbe_rpt_t    rpt;
		logic        rpt_v;
		mbe_rpt_t    last;
		logic        ack;
		logic [31:0] rdat;
	} mbe_st_t;

	mbe_st_t st;
	mbe_st_t next_st;

	logic        erl_done;
	logic        erl_perr;
	logic [15:0] erl_msg;

	logic        test_on;
	logic        is_mcu;
	logic        par_en;
	logic        lock_en;
	logic [1:0]  chk_seen;
	logic        par_err;
	mbe_arb_t    chk_arb;
	logic        arb_err;
	mbe_rpt_t    cand;
	logic        wr_hit;
	logic [16:0] wr_to;

	mbe_erl_rx u_erl (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.bit_valid_i (erl_bit_valid_i),
		.bit_i       (error_report_line_i),
		.force_err_i (test_on),
		.done_o      (erl_done),
		.par_err_o   (erl_perr),
		.msg_o       (erl_msg)
	);

	// ----------------------------------------------------------------
	// Detection
	// ----------------------------------------------------------------
	always_comb begin
		test_on  = st.ctrl[MBE_CTRL_TEST];
		is_mcu   = st.ctrl[MBE_CTRL_IS_MCU];
		par_en   = !st.ctrl[MBE_CTRL_PAR_DIS] || test_on;
		lock_en  = !st.ctrl[MBE_CTRL_LOCK_DIS] || test_on;
		// Test mode inverts the checker side only while this node drives read data.
		chk_seen = memory_bus_data_i.chk;
		if (test_on && own_read_data_i) begin
			chk_seen = ~memory_bus_data_i.chk;
		end
		par_err = par_en && memory_bus_data_i.valid
			&& (chk_seen != mbe_par_gen(memory_bus_data_i.sig));
		// In test mode the master side is inverted, so agreeing inputs must mismatch.
		chk_arb = test_on ? ~arb_master_i : arb_master_i;
		arb_err = lock_en && (chk_arb != arb_checker_i);
		// Later checks may only raise the report; a module fault overrides all.
		cand = MBE_RPT_NONE;
		if (par_err) begin
			cand = is_mcu ? MBE_RPT_BML : MBE_RPT_PARITY;
		end
		if (erl_done && erl_perr) begin
			cand = mbe_max(cand, is_mcu ? MBE_RPT_BMH : MBE_RPT_ERL_PAR);
		end
		if (arb_err) begin
			cand = mbe_max(cand, is_mcu ? MBE_RPT_BMH : MBE_RPT_ARB);
		end
		if (module_fault_i) begin
			cand = MBE_RPT_MODULE;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		// The acknowledge is registered and lasts one cycle, so a held request is taken again every second cycle.
		wr_hit = cyc_i && stb_i && we_i && !st.ack;
		wr_to  = dat_i[16:0];
		next_st = st;
		next_st.ack    = cyc_i && stb_i && !st.ack;
		next_st.pseudo = 1'b0;
		next_st.buserr = 1'b0;
		next_st.rpt_v  = 1'b0;
		if (wr_hit && adr_i == MBE_REG_CTRL && sel_i[0]) begin
			next_st.ctrl = dat_i[3:0];
		end
		if (wr_hit && adr_i == MBE_REG_TIMEOUT && sel_i[0]) begin
			if (wr_to < 17'(MBE_TO_MIN)) begin
				next_st.to_dur = 17'(MBE_TO_MIN);
			end else if (wr_to > 17'(MBE_TO_MAX)) begin
				next_st.to_dur = 17'(MBE_TO_MAX);
			end else begin
				next_st.to_dur = wr_to;
			end
		end
		case (adr_i)
			MBE_REG_CTRL:    next_st.rdat = {28'h000_0000, st.ctrl};
			MBE_REG_TIMEOUT: next_st.rdat = {15'h0000, st.to_dur};
			MBE_REG_STATUS:  next_st.rdat = {29'h0000_0000, st.bar, st.halt, st.waiting};
			MBE_REG_REPORT:  next_st.rdat = {erl_msg, 13'h0000, st.last};
			default:         next_st.rdat = 32'h0000_0000;
		endcase
		if (cand != MBE_RPT_NONE) begin
			next_st.rpt   = cand;
			next_st.rpt_v = 1'b1;
			next_st.last  = cand;
		end
		// The memory unit bars the second bus on bus parity with no module fault or arbitration error; an error-line parity error does not prevent it.
		if (is_mcu && par_err && !module_fault_i && !arb_err) begin
			next_st.bar = 1'b1;
		end
		if (is_mcu && erl_stuck_low_i) begin
			next_st.halt = 1'b1;
		end
		// The tick divider restarts with each request, so that every wait
		// is measured in whole ticks from its own start.
		if (st.tick_cnt == 17'(MBE_TICK_CYCLES - 1)) begin
			next_st.tick_cnt = 17'h0_0000;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 17'h0_0001;
		end
		// A reply clears the wait; an expiry answers with a pseudo-reply, never a report.
		if (new_request_line_i) begin
			next_st.waiting  = 1'b1;
			next_st.to_cnt   = 17'h0_0000;
			next_st.tick_cnt = 17'h0_0000;
		end else if (reply_i) begin
			next_st.waiting = 1'b0;
		end else if (st.waiting && st.tick_cnt == 17'(MBE_TICK_CYCLES - 1)) begin
			if (st.to_cnt + 17'h0_0001 >= st.to_dur) begin
				next_st.waiting = 1'b0;
				next_st.pseudo  = 1'b1;
				next_st.buserr  = 1'b1;
			end else begin
				next_st.to_cnt = st.to_cnt + 17'h0_0001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st        <= '0;
			st.ctrl   <= MBE_CTRL_RESET;
			st.to_dur <= MBE_TO_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign dat_o            = st.rdat;
	assign ack_o            = st.ack;
	assign report_o         = st.rpt;
	assign report_valid_o   = st.rpt_v;
	assign pseudo_reply_o   = st.pseudo;
	assign bus_error_o      = st.buserr;
	assign halt_o           = st.halt;
	assign second_bus_bar_o = st.bar;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_module_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		module_fault_i |=> report_valid_o && report_o == MBE_RPT_MODULE)
		else $error("module fault not reported as module error");
	a_biu_parity: assert property (@(posedge clk_i) disable iff (rst_i)
		par_err && !is_mcu && !arb_err && !module_fault_i && !erl_done
		|=> report_o == MBE_RPT_PARITY)
		else $error("interface unit parity not reported as bus parity");
	a_mcu_parity: assert property (@(posedge clk_i) disable iff (rst_i)
		par_err && is_mcu && !arb_err && !module_fault_i && !erl_done
		|=> report_o == MBE_RPT_BML && second_bus_bar_o)
		else $error("memory unit parity not reported as bus/module-low");
	a_arb_class: assert property (@(posedge clk_i) disable iff (rst_i)
		arb_err && is_mcu && !module_fault_i |=> report_o == MBE_RPT_BMH)
		else $error("memory unit arbitration not bus/module-high");
	a_test_detect: assert property (@(posedge clk_i) disable iff (rst_i)
		test_on && !module_fault_i && arb_master_i == arb_checker_i
		|=> report_valid_o)
		else $error("test detection did not force an error");
	a_halt_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
		is_mcu && erl_stuck_low_i |=> halt_o [*2])
		else $error("halt on stuck error line not held");
	a_timeout_pair: assert property (@(posedge clk_i) disable iff (rst_i)
		pseudo_reply_o |-> bus_error_o
			&& report_valid_o == $past(cand != MBE_RPT_NONE))
		else $error("timeout pseudo-reply mismatch");
	a_reply_stops: assert property (@(posedge clk_i) disable iff (rst_i)
		reply_i && !new_request_line_i |=> !st.waiting ##1 !pseudo_reply_o)
		else $error("reply did not stop the timeout");
	a_wait_starts: assert property (@(posedge clk_i) disable iff (rst_i)
		new_request_line_i |=> st.waiting && !pseudo_reply_o)
		else $error("request did not start the timeout");
	a_idle_no_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
		!st.waiting && !new_request_line_i |=> !pseudo_reply_o)
		else $error("expiry without a pending request");
	a_to_range: assert property (@(posedge clk_i) disable iff (rst_i)
		st.to_dur >= 17'(MBE_TO_MIN) && st.to_dur <= 17'(MBE_TO_MAX))
		else $error("timeout duration out of range");

	// ----------------------------------------------------------------
	// Checks: detection and test
	// ----------------------------------------------------------------
	a_par_off: assert property (@(posedge clk_i) disable iff (rst_i)
		st.ctrl[MBE_CTRL_PAR_DIS] && !test_on |-> !par_err)
		else $error("disabled bus parity still flagged");
	a_lock_off: assert property (@(posedge clk_i) disable iff (rst_i)
		st.ctrl[MBE_CTRL_LOCK_DIS] && !test_on |-> !arb_err)
		else $error("disabled lockstep compare still flagged");
	a_test_parity: assert property (@(posedge clk_i) disable iff (rst_i)
		test_on && own_read_data_i && memory_bus_data_i.valid
		&& memory_bus_data_i.chk == mbe_par_gen(memory_bus_data_i.sig) |-> par_err)
		else $error("test detection did not invert the check bits");
	a_test_arb: assert property (@(posedge clk_i) disable iff (rst_i)
		test_on && arb_master_i == arb_checker_i |-> arb_err)
		else $error("test detection did not invert the comparators");

	// ----------------------------------------------------------------
	// Checks: classification and sticky outcomes
	// ----------------------------------------------------------------
	a_arb_iu: assert property (@(posedge clk_i) disable iff (rst_i)
		arb_err && !is_mcu && !module_fault_i |=> report_o == MBE_RPT_ARB)
		else $error("interface unit arbitration not bus arbitration");
	a_erl_class: assert property (@(posedge clk_i) disable iff (rst_i)
		erl_done && erl_perr && !arb_err && !module_fault_i
		|=> report_valid_o && report_o == (is_mcu ? MBE_RPT_BMH : MBE_RPT_ERL_PAR))
		else $error("error-line parity wrongly classified");
	a_quiet_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		cand == MBE_RPT_NONE |=> !report_valid_o)
		else $error("report issued without a detected error");
	a_report_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		!report_valid_o |-> $stable(report_o))
		else $error("report code changed without a report");
	a_bar_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		!second_bus_bar_o && !(is_mcu && par_err) |=> !second_bus_bar_o)
		else $error("second bus barred without memory unit parity");
	a_bar_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
		second_bus_bar_o |=> second_bus_bar_o)
		else $error("second bus bar released");
	a_halt_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		!halt_o && !(is_mcu && erl_stuck_low_i) |=> !halt_o)
		else $error("halt without a stuck error line");

endmodule

`default_nettype wire

// >>> core/mbe_erl_rx.sv
`timescale 1ns/100ps
`default_nettype none

// Receives one serial error-report message (16 bits, then even parity).
module mbe_erl_rx
	import mbe_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        bit_valid_i,
	input  wire logic        bit_i,
	input  wire logic        force_err_i,
	output logic             done_o,
	output logic             par_err_o,
	output logic [15:0]      msg_o
);

	typedef struct packed {
		logic [4:0]  cnt;
		logic [15:0] shreg;
		logic        par;
		logic        done;
		logic        perr;
		logic [15:0] msg;
	} mbe_erl_st_t;

	mbe_erl_st_t st;
	mbe_erl_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (bit_valid_i) begin
			if (st.cnt == 5'(MBE_ERL_BITS)) begin
				next_st.cnt  = 5'h00;
				next_st.done = 1'b1;
				next_st.msg  = st.shreg;
				next_st.perr = (st.par ^ bit_i) | force_err_i;
				next_st.par  = 1'b0;
			end else begin
				next_st.cnt   = st.cnt + 5'h01;
				next_st.shreg = {st.shreg[14:0], bit_i};
				next_st.par   = st.par ^ bit_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done_o    = st.done;
	assign par_err_o = st.perr;
	assign msg_o     = st.msg;

endmodule

`default_nettype wire

// >>> core/mbe_pkg.sv
package mbe_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the Wishbone slave)
	// ----------------------------------------------------------------
	localparam logic [3:0] MBE_REG_CTRL    = 4'h0;
	localparam logic [3:0] MBE_REG_TIMEOUT = 4'h4;
	localparam logic [3:0] MBE_REG_STATUS  = 4'h8;
	localparam logic [3:0] MBE_REG_REPORT  = 4'hC;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int MBE_CTRL_PAR_DIS  = 0;
	localparam int MBE_CTRL_LOCK_DIS = 1;
	localparam int MBE_CTRL_TEST     = 2;
	localparam int MBE_CTRL_IS_MCU   = 3;
	localparam logic [3:0] MBE_CTRL_RESET = 4'h0;

	// ----------------------------------------------------------------
	// Timing: timeout tick is 16 us, duration register counts ticks
	// ----------------------------------------------------------------
	localparam int MBE_CLK_MHZ     = 125;
	localparam int MBE_TICK_US     = 16;
	localparam int MBE_TICK_CYCLES = MBE_TICK_US * MBE_CLK_MHZ;
	localparam int MBE_TO_MIN      = 1;
	localparam int MBE_TO_MAX      = 125000;
	localparam logic [16:0] MBE_TO_RESET = 17'h1_E848;

	// ----------------------------------------------------------------
	// Link widths
	// ----------------------------------------------------------------
	localparam int MBE_BUS_BITS = 19;
	localparam int MBE_ERL_BITS = 16;

	// Error report codes; a larger code outranks a smaller one.
	typedef enum logic [2:0] {
		MBE_RPT_NONE    = 3'h0,
		MBE_RPT_BML     = 3'h1,
		MBE_RPT_PARITY  = 3'h2,
		MBE_RPT_BMH     = 3'h3,
		MBE_RPT_ERL_PAR = 3'h4,
		MBE_RPT_ARB     = 3'h5,
		MBE_RPT_MODULE  = 3'h6
	} mbe_rpt_t;

	typedef struct packed {
		logic [18:0] sig;
		logic [1:0]  chk;
		logic        valid;
	} mbe_xfer_t;

	typedef struct packed {
		logic bus_grant_out;
		logic request_out;
	} mbe_arb_t;

endpackage

// >>> dv/mbe_far_node.sv
`timescale 1ns/100ps
`default_nettype none

// Far node on the shared bus: sends transfers and error-report messages.
module mbe_far_node
	import mbe_pkg::*;
(
	input  wire logic clk_i,
	output mbe_xfer_t xfer_o,
	output logic      erl_valid_o,
	output logic      erl_bit_o
);
	initial begin
		xfer_o = '0;
		erl_valid_o = 1'b0;
		erl_bit_o = 1'b1;
	end

	// A set bit of bad spoils the matching check bit.
	task automatic send(input logic [18:0] s, input logic [1:0] bad);
		mbe_xfer_t x;
		x.sig = s;
		x.chk[0] = ~^(s & 19'h5_5555) ^ bad[0];
		x.chk[1] = ^(s & 19'h2_AAAA) ^ bad[1];
		x.valid = 1'b1;
		@(posedge clk_i);
		xfer_o <= x;
		@(posedge clk_i);
		xfer_o <= '{sig: ~s, chk: ~x.chk, valid: 1'b0};
	endtask

	task automatic send_msg(input logic [15:0] m, input logic bad);
		for (int i = 0; i < 17; i++) begin
			@(posedge clk_i);
			erl_valid_o <= 1'b1;
			erl_bit_o <= (i < 16) ? m[15 - i] : (^m ^ bad);
		end
		@(posedge clk_i);
		erl_valid_o <= 1'b0;
		erl_bit_o <= 1'b1;
	endtask
endmodule

`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb
	import mbe_pkg::*;
;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [3:0]  adr_i, sel_i;
	logic [31:0] dat_i, dat_o;
	mbe_xfer_t   xfer;
	mbe_arb_t    arb_m, arb_c;
	logic        own_rd, mfault, new_request_line, reply, ev, eb, stuck;
	mbe_rpt_t    report_o, last;
	logic        rv, pr, be, halt, bar;
	int          num_errors, n_tests, nrpt, npr;

	mbe_classifier u_mbe_classifier (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.memory_bus_data_i(xfer), .own_read_data_i(own_rd), .arb_master_i(arb_m),
		.arb_checker_i(arb_c), .module_fault_i(mfault), .new_request_line_i(new_request_line),
		.reply_i(reply), .erl_bit_valid_i(ev), .error_report_line_i(eb),
		.erl_stuck_low_i(stuck), .report_o(report_o), .report_valid_o(rv),
		.pseudo_reply_o(pr), .bus_error_o(be), .halt_o(halt), .second_bus_bar_o(bar)
	);

	mbe_far_node u_far (.clk_i(clk_i), .xfer_o(xfer), .erl_valid_o(ev), .erl_bit_o(eb));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (rv === 1'b1) begin
			nrpt++;
			last = report_o;
		end
		if (pr === 1'b1) begin
			npr++;
			chk("bus error", 1, be);
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'hF;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(nm, e, q);
	endtask

	task automatic expect_rpt(input int n, input mbe_rpt_t c);
		repeat (4) @(posedge clk_i);
		chk("report count", n, nrpt);
		if (n > 0)
			chk("report code", c, last);
		nrpt = 0;
	endtask

	task automatic arb_glitch();
		@(posedge clk_i);
		arb_c <= 2'b10;
		@(posedge clk_i);
		arb_c <= 2'b11;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_iu_detect();
		u_far.send(19'h5_A5A5, 2'b00);
		expect_rpt(0, MBE_RPT_NONE);
		u_far.send(19'h5_A5A5, 2'b10);
		expect_rpt(1, MBE_RPT_PARITY);
		arb_glitch();
		expect_rpt(1, MBE_RPT_ARB);
		u_far.send_msg(16'h1234, 1'b1);
		expect_rpt(1, MBE_RPT_ERL_PAR);
	endtask

	task automatic t_priority();
		fork
			u_far.send(19'h0_0001, 2'b01);
			begin
				@(posedge clk_i);
				mfault <= 1'b1;
				arb_c <= 2'b10;
				@(posedge clk_i);
				mfault <= 1'b0;
				arb_c <= 2'b11;
			end
		join
		expect_rpt(1, MBE_RPT_MODULE);
	endtask

	task automatic t_disables();
		wr(MBE_REG_CTRL, 32'h0000_0003);
		u_far.send(19'h7_FFFF, 2'b11);
		arb_glitch();
		expect_rpt(0, MBE_RPT_NONE);
		u_far.send_msg(16'hFFFF, 1'b1);
		expect_rpt(1, MBE_RPT_ERL_PAR);
		wr(MBE_REG_CTRL, 32'h0000_0007);
		repeat (2) @(posedge clk_i);
		chk("test arb report", MBE_RPT_ARB, last);
		arb_c <= 2'b00;
		repeat (2) @(posedge clk_i);
		nrpt = 0;
		own_rd <= 1'b1;
		u_far.send(19'h0_00F0, 2'b00);
		own_rd <= 1'b0;
		expect_rpt(1, MBE_RPT_PARITY);
		u_far.send_msg(16'h0F0F, 1'b0);
		expect_rpt(1, MBE_RPT_ERL_PAR);
		wr(MBE_REG_CTRL, 32'h0000_0000);
		arb_c <= 2'b11;
		repeat (4) @(posedge clk_i);
		nrpt = 0;
	endtask

	task automatic t_timeout();
		wr(MBE_REG_TIMEOUT, 32'h0000_0000);
		rd_chk("timeout clamp", MBE_REG_TIMEOUT, 32'(MBE_TO_MIN));
		@(posedge clk_i);
		new_request_line <= 1'b1;
		@(posedge clk_i);
		new_request_line <= 1'b0;
		repeat (2100) @(posedge clk_i);
		chk("pseudo reply", 1, npr);
		chk("timeout report", 0, nrpt);
		new_request_line <= 1'b1;
		@(posedge clk_i);
		new_request_line <= 1'b0;
		repeat (100) @(posedge clk_i);
		reply <= 1'b1;
		@(posedge clk_i);
		reply <= 1'b0;
		repeat (2500) @(posedge clk_i);
		chk("pseudo reply after reply", 1, npr);
	endtask

	task automatic t_mcu();
		wr(MBE_REG_CTRL, 32'h0000_0008);
		u_far.send(19'h1_2345, 2'b01);
		expect_rpt(1, MBE_RPT_BML);
		chk("second bus bar", 1, bar);
		arb_glitch();
		expect_rpt(1, MBE_RPT_BMH);
		u_far.send_msg(16'h00FF, 1'b1);
		expect_rpt(1, MBE_RPT_BMH);
		rd_chk("report reg", MBE_REG_REPORT, 32'h00FF_0003);
		chk("halt before", 0, halt);
		stuck <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("halt", 1, halt);
		rd_chk("status reg", MBE_REG_STATUS, 32'h0000_0006);
	endtask

	initial begin
		{cyc_i, stb_i, we_i, own_rd, mfault, new_request_line, reply, stuck} = '0;
		adr_i = 4'h0;
		sel_i = 4'hF;
		dat_i = 32'h0000_0000;
		arb_m = 2'b11;
		arb_c = 2'b11;
		{num_errors, n_tests, nrpt, npr} = '0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("ctrl reset", MBE_REG_CTRL, 32'h0000_0000);
		rd_chk("timeout reset", MBE_REG_TIMEOUT, 32'h0001_E848);
		nrpt = 0;
		t_iu_detect();
		t_priority();
		t_disables();
		t_timeout();
		t_mcu();
		summarize();
	end

	initial begin
		#400000;
		num_errors++;
		summarize();
	end
endmodule

`default_nettype wire
